// ### nsut_phase_source.sv
// three-phase current phasor source standing in for the measurement front end
module nsut_phase_source (
    input  wire logic               clk_sys,
    input  wire logic        [15:0] amp,
    input  wire logic        [1:0]  pat,
    output logic signed      [15:0] ia_re,
    output logic signed      [15:0] ia_im,
    output logic signed      [15:0] ib_re,
    output logic signed      [15:0] ib_im,
    output logic signed      [15:0] ic_re,
    output logic signed      [15:0] ic_im
);
    timeunit 1ns;
    timeprecision 1ps;
    logic signed [31:0] a;
    logic signed [31:0] h;
    logic signed [31:0] s;
    assign a = {16'h0000, amp};
    assign h = a >>> 1;
    assign s = (a * 32'sd28378) >>> 15;
    // pattern 0 abc, 1 phase a only, 2 acb, 3 abc with phase a doubled
    always_ff @(posedge clk_sys) begin
        ia_re <= (pat == 2'd3) ? 16'(a <<< 1) : 16'(a);
        ia_im <= 16'h0000;
        ib_re <= (pat == 2'd1) ? 16'h0000 : 16'(-h);
        ib_im <= (pat == 2'd1) ? 16'h0000 : (pat == 2'd2) ? 16'(s) : 16'(-s);
        ic_re <= (pat == 2'd1) ? 16'h0000 : 16'(-h);
        ic_im <= (pat == 2'd1) ? 16'h0000 : (pat == 2'd2) ? 16'(-s) : 16'(s);
    end
endmodule // nsut_phase_source

// ### nsut_pkg.sv
// types of the unbalance trip: delay characteristic and the whole register state
package nsut_pkg;

    typedef enum logic {
        mode_definite,
        mode_inverse
    } nsut_mode_t;

    typedef struct packed {
        logic [31:0] tick_cnt;
        logic        aw_ok;
        logic [7:0]  aw_addr;
        logic        w_ok;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [3:0]  ctrl;
        logic [15:0] thresh;
        logic [6:0]  ratio;
        logic [23:0] delay;
        logic [15:0] kcap;
        logic [5:0]  tau;
        logic [1:0]  sts;
        logic [1:0]  mask;
        logic        pick;
        logic        trip;
        logic        heat;
        logic [23:0] dcnt;
        logic [55:0] theta;
        logic        irq;
    } nsut_state_t;

endpackage

// ### nsut_regs.svh
// register map, field positions, reset values and timing counts of the unbalance trip
`ifndef NSUT_REGS_SVH
`define NSUT_REGS_SVH

`define NSUT_ADDR_W          8
`define NSUT_OFS_CTRL        8'h00
`define NSUT_OFS_THRESH      8'h04
`define NSUT_OFS_RATIO       8'h08
`define NSUT_OFS_DELAY       8'h0c
`define NSUT_OFS_KCAP        8'h10
`define NSUT_OFS_TAU         8'h14
`define NSUT_OFS_STATUS      8'h18
`define NSUT_OFS_MASK        8'h1c
`define NSUT_OFS_STATE       8'h20

`define NSUT_CTRL_ENABLE     0
`define NSUT_CTRL_INVERSE    1
`define NSUT_CTRL_RATIO_EN   2
`define NSUT_CTRL_ROT_ACB    3

`define NSUT_EV_PICKUP       0
`define NSUT_EV_TRIP         1

`define NSUT_RST_THRESH      16'h0199
`define NSUT_RST_RATIO       7'h0a
`define NSUT_RST_DELAY       24'h000fa0
`define NSUT_RST_KCAP        16'h000a
`define NSUT_RST_TAU         6'h0e

`define NSUT_RESP_OKAY       2'h0
`define NSUT_RESP_SLVERR     2'h2

// one nominal current equals this many input counts
`define NSUT_NOM_COUNTS      4096
`define NSUT_NOM_SQ          (56'd4096 * 56'd4096)
`define NSUT_CLK_PERIOD_NS   10
`define NSUT_SAMPLE_PERIOD_NS 250000
`define NSUT_SAMPLE_CYCLES   (`NSUT_SAMPLE_PERIOD_NS / `NSUT_CLK_PERIOD_NS)
`define NSUT_SAMPLES_PER_S   (1000000000 / `NSUT_SAMPLE_PERIOD_NS)
`define NSUT_COOL_FLOOR_PCT  100
`define NSUT_PCT_SQ          64'd10000
`define NSUT_SQRT3_HALF_Q15  34'sd28378
`define NSUT_THIRD_Q16       36'sd21845

`endif

// ### nsut_unbalance_trip.sv
// negative-sequence current unbalance trip element with axi4-lite settings
//
// Overview of operation
// - positive and negative sequence formed from three phases, honouring phase rotation
// - unbalance ratio is negative over positive sequence, checked against ratio pickup
// - trip needs sequence current over threshold, plus ratio if enabled, held for delay
// - threshold is in input counts, the allowed continuous unbalance
// - mode selects programmed definite delay or self-computed inverse delay
// - definite mode trips once the condition held continuously for programmed delay
// - thermal energy updates every sample, whatever the trip state or mode
// - inverse mode trips when condition holds and energy exceeds capability-derived maximum
// - from zero energy, delay equals capability times nominal squared over squares difference
// - residual energy shortens the inverse delay
// - while over threshold, energy integrates negative sequence squared minus threshold squared, unscaled
// - heating starts from energy left by cooling, or zero if cooling ended
// - while below threshold, energy decays exponentially under the cooling constant
// - below one percent of maximum, cooling stops and energy clears to zero
// - thermal energy is internal only, never readable
`include "nsut_regs.svh"

module nsut_unbalance_trip #(
    parameter int unsigned SAMPLE_CYCLES = `NSUT_SAMPLE_CYCLES
) (
    input  wire logic                     clk_sys,
    input  wire logic                     nrst,
    input  wire logic                     ce,
    input  wire logic signed [15:0]       ia_re,
    input  wire logic signed [15:0]       ia_im,
    input  wire logic signed [15:0]       ib_re,
    input  wire logic signed [15:0]       ib_im,
    input  wire logic signed [15:0]       ic_re,
    input  wire logic signed [15:0]       ic_im,
    output logic                          trip,
    output logic                          irq,
    input  wire logic [`NSUT_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [`NSUT_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready
);

    nsut_pkg::nsut_state_t st_ff;
    nsut_pkg::nsut_state_t nxt_st;

    // ia + a*x + a^2*y, divided by three; returns {re, im}
    function automatic logic [35:0] seq_sum(input logic signed [15:0] ar, input logic signed [15:0] ai,
                                            input logic signed [15:0] xr, input logic signed [15:0] xi,
                                            input logic signed [15:0] yr, input logic signed [15:0] yi);
        logic signed [33:0] kxr, kxi, kyr, kyi;
        logic signed [19:0] sr, si;
        logic signed [35:0] qr, qi;
        kxr = 34'(xr) * `NSUT_SQRT3_HALF_Q15;
        kxi = 34'(xi) * `NSUT_SQRT3_HALF_Q15;
        kyr = 34'(yr) * `NSUT_SQRT3_HALF_Q15;
        kyi = 34'(yi) * `NSUT_SQRT3_HALF_Q15;
        sr  = 20'(ar) - 20'(xr >>> 1) - 20'(kxi >>> 15) - 20'(yr >>> 1) + 20'(kyi >>> 15);
        si  = 20'(ai) + 20'(kxr >>> 15) - 20'(xi >>> 1) - 20'(kyr >>> 15) - 20'(yi >>> 1);
        qr  = 36'(sr) * `NSUT_THIRD_Q16;
        qi  = 36'(si) * `NSUT_THIRD_Q16;
        return {18'(qr >>> 16), 18'(qi >>> 16)};
    endfunction

    function automatic logic [39:0] mag_sq(input logic [35:0] v);
        logic signed [17:0] re, im;
        logic signed [35:0] pr, pi;
        re = v[35:18];
        im = v[17:0];
        pr = 36'(re) * 36'(re);
        pi = 36'(im) * 36'(im);
        return 40'($unsigned(pr)) + 40'($unsigned(pi));
    endfunction

    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [35:0] pos_seq;
    logic [35:0] neg_seq;
    logic [39:0] i1_sq;
    logic [39:0] i2_sq;
    logic [31:0] thr_sq;
    logic        over;
    logic        ratio_ok;
    logic        cond;
    logic        tick;
    logic        enabled;
    logic [55:0] theta_max;
    logic [55:0] theta_heat;
    logic [55:0] theta_cool;
    logic [55:0] cool_step;

    always_comb begin
        tick    = (st_ff.tick_cnt == SAMPLE_CYCLES - 1);
        enabled = st_ff.ctrl[`NSUT_CTRL_ENABLE];
        if (!st_ff.ctrl[`NSUT_CTRL_ROT_ACB]) begin
            pos_seq = seq_sum(ia_re, ia_im, ib_re, ib_im, ic_re, ic_im);
            neg_seq = seq_sum(ia_re, ia_im, ic_re, ic_im, ib_re, ib_im);
        end else begin
            pos_seq = seq_sum(ia_re, ia_im, ic_re, ic_im, ib_re, ib_im);
            neg_seq = seq_sum(ia_re, ia_im, ib_re, ib_im, ic_re, ic_im);
        end
        i1_sq    = mag_sq(pos_seq);
        i2_sq    = mag_sq(neg_seq);
        thr_sq   = 32'(st_ff.thresh) * 32'(st_ff.thresh);
        over     = i2_sq > 40'(thr_sq);
        // squared form of i2/i1*100 > ratio pickup
        ratio_ok = 64'(i2_sq) * `NSUT_PCT_SQ >
                   64'(14'(st_ff.ratio) * 14'(st_ff.ratio)) * 64'(i1_sq);
        cond     = over && (!st_ff.ctrl[`NSUT_CTRL_RATIO_EN] || ratio_ok);
        // capability seconds -> energy in counts^2 * samples
        theta_max = 56'(st_ff.kcap) * 56'(`NSUT_SAMPLES_PER_S) * `NSUT_NOM_SQ;
        // integrate i2^2 - thr^2 so the delay from zero matches the capability curve
        theta_heat = st_ff.theta + 56'(i2_sq - 40'(thr_sq));
        if (theta_heat < st_ff.theta) begin
            theta_heat = '1;
        end
        cool_step = st_ff.theta >> st_ff.tau;
        if (cool_step == 56'h0) begin
            cool_step = 56'h1;
        end
        if (st_ff.theta <= cool_step) begin
            theta_cool = 56'h0;
        end else begin
            theta_cool = st_ff.theta - cool_step;
        end
        if (64'(theta_cool) * 64'(`NSUT_COOL_FLOOR_PCT) < 64'(theta_max)) begin
            theta_cool = 56'h0;
        end
    end

    always_comb begin
        logic [1:0]  ev;
        logic [1:0]  rd_clr;
        logic [23:0] dnext;
        logic [31:0] wv;
        ev     = 2'h0;
        rd_clr = 2'h0;
        dnext  = 24'h0;
        wv     = 32'h0;
        nxt_st = st_ff;

        nxt_st.tick_cnt = tick ? 32'h0 : st_ff.tick_cnt + 32'h1;

        // write channel: address and data taken in either order
        if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.aw_ok   = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.w_ok  = 1'b1;
            nxt_st.wdata = s_axi_wdata;
            nxt_st.wstrb = s_axi_wstrb;
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (st_ff.aw_ok && st_ff.w_ok && !st_ff.bvalid) begin
            nxt_st.aw_ok  = 1'b0;
            nxt_st.w_ok   = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp  = `NSUT_RESP_OKAY;
            case (st_ff.aw_addr)
                `NSUT_OFS_CTRL: begin
                    wv = strb_merge(32'(st_ff.ctrl), st_ff.wdata, st_ff.wstrb);
                    nxt_st.ctrl = wv[3:0];
                end
                `NSUT_OFS_THRESH: begin
                    wv = strb_merge(32'(st_ff.thresh), st_ff.wdata, st_ff.wstrb);
                    nxt_st.thresh = wv[15:0];
                end
                `NSUT_OFS_RATIO: begin
                    wv = strb_merge(32'(st_ff.ratio), st_ff.wdata, st_ff.wstrb);
                    nxt_st.ratio = wv[6:0];
                end
                `NSUT_OFS_DELAY: begin
                    wv = strb_merge(32'(st_ff.delay), st_ff.wdata, st_ff.wstrb);
                    nxt_st.delay = wv[23:0];
                end
                `NSUT_OFS_KCAP: begin
                    wv = strb_merge(32'(st_ff.kcap), st_ff.wdata, st_ff.wstrb);
                    nxt_st.kcap = wv[15:0];
                end
                `NSUT_OFS_TAU: begin
                    wv = strb_merge(32'(st_ff.tau), st_ff.wdata, st_ff.wstrb);
                    nxt_st.tau = wv[5:0];
                end
                `NSUT_OFS_MASK: begin
                    wv = strb_merge(32'(st_ff.mask), st_ff.wdata, st_ff.wstrb);
                    nxt_st.mask = wv[1:0];
                end
                `NSUT_OFS_STATUS, `NSUT_OFS_STATE: begin
                end
                default: begin
                    nxt_st.bresp = `NSUT_RESP_SLVERR;
                end
            endcase
        end
        nxt_st.awready = !nxt_st.aw_ok && !nxt_st.bvalid;
        nxt_st.wready  = !nxt_st.w_ok && !nxt_st.bvalid;

        // read channel; energy has no address
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_ff.arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = `NSUT_RESP_OKAY;
            case (s_axi_araddr)
                `NSUT_OFS_CTRL:   nxt_st.rdata = 32'(st_ff.ctrl);
                `NSUT_OFS_THRESH: nxt_st.rdata = 32'(st_ff.thresh);
                `NSUT_OFS_RATIO:  nxt_st.rdata = 32'(st_ff.ratio);
                `NSUT_OFS_DELAY:  nxt_st.rdata = 32'(st_ff.delay);
                `NSUT_OFS_KCAP:   nxt_st.rdata = 32'(st_ff.kcap);
                `NSUT_OFS_TAU:    nxt_st.rdata = 32'(st_ff.tau);
                `NSUT_OFS_MASK:   nxt_st.rdata = 32'(st_ff.mask);
                `NSUT_OFS_STATE:  nxt_st.rdata = 32'({st_ff.heat, st_ff.trip, st_ff.pick});
                `NSUT_OFS_STATUS: begin
                    nxt_st.rdata = 32'(st_ff.sts);
                    rd_clr       = 2'h3;
                end
                default: begin
                    nxt_st.rdata = 32'h0;
                    nxt_st.rresp = `NSUT_RESP_SLVERR;
                end
            endcase
        end
        nxt_st.arready = !nxt_st.rvalid;

        // protection update once per sample
        if (tick) begin
            if (!enabled) begin
                nxt_st.pick  = 1'b0;
                nxt_st.trip  = 1'b0;
                nxt_st.heat  = 1'b0;
                nxt_st.dcnt  = 24'h0;
                nxt_st.theta = 56'h0;
            end else begin
                nxt_st.pick  = cond;
                nxt_st.heat  = over;
                // energy tracks in every mode; heating resumes from what cooling left
                nxt_st.theta = over ? theta_heat : theta_cool;
                dnext = cond ? ((st_ff.dcnt == '1) ? st_ff.dcnt : st_ff.dcnt + 24'h1) : 24'h0;
                nxt_st.dcnt = dnext;
                if (nsut_pkg::nsut_mode_t'(st_ff.ctrl[`NSUT_CTRL_INVERSE]) ==
                    nsut_pkg::mode_definite) begin
                    nxt_st.trip = cond && (dnext >= st_ff.delay);
                end else begin
                    // residual energy reaches the maximum sooner
                    nxt_st.trip = cond && (theta_heat >= theta_max);
                end
                ev[`NSUT_EV_PICKUP] = cond && !st_ff.pick;
                ev[`NSUT_EV_TRIP]   = nxt_st.trip && !st_ff.trip;
            end
        end
        // a new event wins over the read that clears
        nxt_st.sts = (st_ff.sts & ~rd_clr) | ev;
        nxt_st.irq = |(nxt_st.sts & nxt_st.mask);
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st_ff        <= '0;
            st_ff.thresh <= `NSUT_RST_THRESH;
            st_ff.ratio  <= `NSUT_RST_RATIO;
            st_ff.delay  <= `NSUT_RST_DELAY;
            st_ff.kcap   <= `NSUT_RST_KCAP;
            st_ff.tau    <= `NSUT_RST_TAU;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign trip          = st_ff.trip;
    assign irq           = st_ff.irq;
    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready  = st_ff.wready;
    assign s_axi_bvalid  = st_ff.bvalid;
    assign s_axi_bresp   = st_ff.bresp;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rvalid  = st_ff.rvalid;
    assign s_axi_rdata   = st_ff.rdata;
    assign s_axi_rresp   = st_ff.rresp;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_sample_cond;
        ce && tick && enabled && cond;
    endsequence

    sequence s_trip_rise;
        $rose(st_ff.trip);
    endsequence

    a_trip_needs_pick: assert property (st_ff.trip |-> st_ff.pick)
        else $error("trip without pickup condition");
    a_ratio_gates: assert property (ce && tick && enabled && over &&
                                    st_ff.ctrl[`NSUT_CTRL_RATIO_EN] && !ratio_ok |=> !st_ff.pick)
        else $error("pickup despite failed ratio check");
    a_definite_wait: assert property (s_trip_rise ##0 !st_ff.ctrl[`NSUT_CTRL_INVERSE] |->
                                      st_ff.dcnt >= st_ff.delay)
        else $error("definite trip before delay elapsed");
    a_inverse_energy: assert property (s_trip_rise ##0 st_ff.ctrl[`NSUT_CTRL_INVERSE] &&
                                       $stable(st_ff.kcap) |-> st_ff.theta >= theta_max)
        else $error("inverse trip below energy maximum");
    a_heat_rises: assert property (ce && tick && enabled && over &&
                                   st_ff.theta < 56'h1000000 |=> st_ff.theta > $past(st_ff.theta))
        else $error("energy did not grow while heating");
    a_cool_falls: assert property (ce && tick && enabled && !over &&
                                   st_ff.theta != 56'h0 |=> st_ff.theta < $past(st_ff.theta))
        else $error("energy did not decay while cooling");
    a_cool_floor: assert property (ce && tick && enabled && !over
                                   |=> st_ff.theta == 56'h0 ||
                                       64'(st_ff.theta) * 64'(`NSUT_COOL_FLOOR_PCT) >= 64'(theta_max))
        else $error("energy left below one percent floor");
    a_sample_pick: assert property (s_sample_cond |=> st_ff.pick ##1 !tick)
        else $error("sample condition not registered");
    a_irq_level: assert property (ce ##1 1'b1 |-> irq == |(st_ff.sts & st_ff.mask))
        else $error("interrupt level disagrees with status");
    a_bvalid_hold: assert property (st_ff.bvalid && !s_axi_bready && ce |=> st_ff.bvalid)
        else $error("write response dropped early");

endmodule // nsut_unbalance_trip

// ### test_negative_sequence_unbalance_trip.sv
// self-checking bench of the unbalance trip: bus tasks, definite and inverse trip timing
`include "nsut_regs.svh"

module test_negative_sequence_unbalance_trip;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int SC = 8;
    logic               clk_sys;
    logic               nrst;
    logic               ce;
    logic signed [15:0] ia_re, ia_im, ib_re, ib_im, ic_re, ic_im;
    logic               trip, irq;
    logic [7:0]         s_axi_awaddr, s_axi_araddr;
    logic [31:0]        s_axi_wdata, s_axi_rdata;
    logic [3:0]         s_axi_wstrb;
    logic [1:0]         s_axi_bresp, s_axi_rresp;
    logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic               s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic               s_axi_rvalid, s_axi_rready;
    logic [15:0]        amp;
    logic [1:0]         pat;
    logic [31:0]        d;
    logic [1:0]         r;
    int                 n_fail = 0;
    int                 checks_done = 0;
    int                 n;
    logic [3:0]         strb = 4'hf;
    logic [7:0]         rofs [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
    logic [31:0]        rval [9] = '{32'h0, 32'h199, 32'ha, 32'hfa0, 32'ha, 32'he, 32'h0, 32'h0, 32'h0};

    nsut_unbalance_trip #(.SAMPLE_CYCLES(SC)) i_dut (
        .clk_sys, .nrst, .ce, .ia_re, .ia_im, .ib_re, .ib_im, .ic_re, .ic_im, .trip, .irq,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready
    );
    nsut_phase_source i_src (
        .clk_sys, .amp, .pat, .ia_re, .ia_im, .ib_re, .ib_im, .ic_re, .ic_im
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_win(input string what, input int lo, input int hi, input int got);
        checks_done++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    // write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] rs);
        logic pa, pw, tb;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= wd;
        s_axi_wstrb <= strb;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge clk_sys);
            pa = s_axi_awvalid && (s_axi_awready === 1'b1);
            pw = s_axi_wvalid && (s_axi_wready === 1'b1);
            tb = (s_axi_bvalid === 1'b1);
            rs = s_axi_bresp;
            @(posedge clk_sys);
            if (pa) s_axi_awvalid <= 1'b0;
            if (pw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] rdat, output logic [1:0] rs);
        logic t;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        t = 1'b0;
        while (!t) begin
            @(negedge clk_sys);
            t = (s_axi_arready === 1'b1);
            @(posedge clk_sys);
        end
        s_axi_arvalid <= 1'b0;
        t = 1'b0;
        while (!t) begin
            @(negedge clk_sys);
            t = (s_axi_rvalid === 1'b1);
            rdat = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge clk_sys);
        end
        s_axi_rready <= 1'b0;
    endtask

    task automatic wo(input logic [7:0] a, input logic [31:0] wd);
        logic [1:0] rs;
        wr(a, wd, rs);
        chk("bresp", {30'h0, `NSUT_RESP_OKAY}, {30'h0, rs});
    endtask

    task automatic rx(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rdat;
        logic [1:0]  rs;
        rd(a, rdat, rs);
        chk("rdata", exp, rdat);
        chk("rresp", {30'h0, `NSUT_RESP_OKAY}, {30'h0, rs});
    endtask

    task automatic src(input logic [1:0] p, input logic [15:0] a);
        @(posedge clk_sys);
        pat <= p;
        amp <= a;
    endtask

    task automatic smp(input int k);
        repeat (k * SC) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    // cycles from now until trip rises, checked against a window
    task automatic wt(input int lo, input int hi);
        int c;
        c = 0;
        while (trip !== 1'b1 && c < 3000) begin
            @(negedge clk_sys);
            c++;
        end
        chk_win("trip delay", lo, hi, c);
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        $display("BAD watchdog expected end seen timeout");
        stop_test();
    end

    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        amp = 16'h0000;
        pat = 2'd0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        n = int'((`NSUT_NOM_SQ * 56'd4000 + 56'd898951423) / 56'd898951424);
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        for (int i = 0; i < 9; i++) rx(rofs[i], rval[i]);
        rd(8'h40, d, r);
        chk("rdata unmapped", 32'h0, d);
        chk("rresp unmapped", 32'h2, {30'h0, r});
        wr(8'h44, 32'h1, r);
        chk("bresp unmapped", 32'h2, {30'h0, r});
        wo(`NSUT_OFS_STATE, 32'h7);
        rx(`NSUT_OFS_STATE, 32'h0);
        // single byte lane write keeps the other lanes
        strb = 4'h2;
        wo(`NSUT_OFS_THRESH, 32'h0000ab00);
        strb = 4'hf;
        rx(`NSUT_OFS_THRESH, 32'h0000ab99);
        // definite delay of five samples, threshold 0.25 of nominal
        wo(`NSUT_OFS_THRESH, 32'h400);
        wo(`NSUT_OFS_DELAY, 32'h5);
        wo(`NSUT_OFS_MASK, 32'h3);
        wo(`NSUT_OFS_CTRL, 32'h1);
        src(2'd0, 16'h1000);
        smp(10);
        rx(`NSUT_OFS_STATE, 32'h0);
        src(2'd1, 16'd3000);
        smp(10);
        chk("trip under threshold", 32'h0, {31'h0, trip});
        src(2'd1, 16'h1000);
        wt(4 * SC, 5 * SC + 3);
        rx(`NSUT_OFS_STATE, 32'h7);
        @(negedge clk_sys);
        chk("irq", 32'h1, {31'h0, irq});
        rx(`NSUT_OFS_STATUS, 32'h3);
        @(negedge clk_sys);
        chk("irq cleared", 32'h0, {31'h0, irq});
        // reversed sequence seen through the matching rotation setting
        wo(`NSUT_OFS_CTRL, 32'h9);
        src(2'd2, 16'h1000);
        smp(10);
        rx(`NSUT_OFS_STATE, 32'h0);
        wo(`NSUT_OFS_MASK, 32'h0);
        rd(`NSUT_OFS_STATUS, d, r);
        wo(`NSUT_OFS_CTRL, 32'h1);
        // clock enable low for 40 cycles stalls the delay timer
        @(posedge clk_sys);
        ce <= 1'b0;
        repeat (40) @(posedge clk_sys);
        ce <= 1'b1;
        wt(3 * SC, 5 * SC + 3);
        chk("irq masked", 32'h0, {31'h0, irq});
        rx(`NSUT_OFS_STATUS, 32'h3);
        // ratio gate: unbalance is 25 percent
        src(2'd0, 16'h0000);
        smp(3);
        wo(`NSUT_OFS_RATIO, 32'd30);
        wo(`NSUT_OFS_CTRL, 32'h5);
        src(2'd3, 16'h1000);
        smp(10);
        rx(`NSUT_OFS_STATE, 32'h4);
        wo(`NSUT_OFS_RATIO, 32'd20);
        wt(3 * SC, 5 * SC + 3);
        // inverse delay from zero energy, one second capability
        src(2'd0, 16'h0000);
        wo(`NSUT_OFS_CTRL, 32'h0);
        wo(`NSUT_OFS_KCAP, 32'h1);
        wo(`NSUT_OFS_CTRL, 32'h3);
        src(2'd2, 16'd30000);
        wt((n - 2) * SC, (n + 1) * SC + 3);
        src(2'd0, 16'h0000);
        smp(4);
        chk("trip after drop", 32'h0, {31'h0, trip});
        src(2'd2, 16'd30000);
        wt(0, 2 * SC + 3);
        src(2'd0, 16'h0000);
        wo(`NSUT_OFS_TAU, 32'h1);
        smp(30);
        wo(`NSUT_OFS_TAU, 32'he);
        src(2'd2, 16'd30000);
        wt((n - 2) * SC, (n + 1) * SC + 3);
        stop_test();
    end
endmodule // test_negative_sequence_unbalance_trip
